// >>> qac_pkg.sv
/*
  constants, field layouts and carrier types for the quadrature angle
  counter channel.
  assumes one 40 MHz clock and a 32-bit AXI4-Lite register port.
*/
// Functional notes
// RULE1 - single precision: count on phase A rise; default
// RULE2 - double precision: count on both A edges
// RULE3 - quad precision: count every A and B edge
// RULE4 - quad gives four times the single count
// RULE5 - quadrature states give the count direction
// RULE6 - external pulse mode clears count per pulse
// RULE7 - non-inverted: high reset level clears to zero
// RULE8 - non-inverted: no counting while reset is high
// RULE9 - reset source gives only brief high pulses; the encoder model can also hold rst_pin high through rst_lvl
// RULE10 - angle spans 0 to 360 degrees, zero offset
// RULE11 - each count scales by 87.891 millidegrees
// RULE12 - reset, B and A shown as event bits
// RULE13 - inverted reset: low clears, high counts
package qac_pkg;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam int          AXI_ADDR_W = 8;
  localparam logic [7:0]  REG_CTRL   = 8'h00;
  localparam logic [7:0]  REG_EVT_EN = 8'h04;
  localparam logic [7:0]  REG_COUNT  = 8'h08;
  localparam logic [7:0]  REG_ANGLE  = 8'h0C;
  localparam logic [7:0]  REG_INPUTS = 8'h10;

  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ****************************************************************
  // field layouts and reset values
  // ****************************************************************
  localparam int          CTRL_W     = 4;
  localparam int          EVT_W      = 3;
  localparam logic [3:0]  CTRL_RST   = 4'h4;
  localparam logic [2:0]  EVT_EN_RST = 3'h7;

  // one rotation is 4096 counts, so the angle uses the low 12 bits
  localparam int          POS_W      = 12;
  // 87.891 millidegrees per count, held in microdegrees
  localparam logic [31:0] ANGLE_STEP_UDEG   = 32'h0001_5753;
  localparam logic [31:0] ANGLE_OFFSET_UDEG = 32'h0000_0000;
  // 360 degrees in microdegrees
  localparam logic [31:0] ANGLE_FULL_UDEG   = 32'h1575_2A00;

  typedef enum logic [1:0] {
    QAC_PREC_SINGLE = 2'b00,
    QAC_PREC_DOUBLE = 2'b01,
    QAC_PREC_QUAD   = 2'b10
  } qac_prec_type;

  typedef struct packed {
    logic         inv;
    logic         ext_rst;
    qac_prec_type prec;
  } qac_ctrl_type;

  typedef struct packed {
    logic rst;
    logic ph_b;
    logic ph_a;
  } qac_inputs_type;

endpackage : qac_pkg

// >>> qac_top.sv
/*
  quadrature angle counter channel with an AXI4-Lite register slave.
  assumes encoder inputs already synchronous to aclk and a master that
  keeps at most one write and one read under way.
*/
// The AXI4-Lite register port and the register offsets were decided locally.
`timescale 1ns/1ps
module qac_top (
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire logic [qac_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output      logic                         s_axi_awready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output      logic                         s_axi_wready,
  output      logic [1:0]                   s_axi_bresp,
  output      logic                         s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [qac_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output      logic                         s_axi_arready,
  output      logic [31:0]                  s_axi_rdata,
  output      logic [1:0]                   s_axi_rresp,
  output      logic                         s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  input  wire logic                         phase_a_input,
  input  wire logic                         phase_b_input,
  input  wire logic                         index_reset_input,
  output      logic [31:0]                  count_value,
  output      logic [31:0]                  angle_value,
  output      logic [2:0]                   event_bits
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  qac_pkg::qac_ctrl_type          ctrl_r;
  logic [qac_pkg::EVT_W-1:0]      evt_en_r;
  qac_pkg::qac_inputs_type        in_s_r;
  qac_pkg::qac_inputs_type        in_p_r;
  logic [31:0]                    count_r;
  logic [31:0]                    angle_r;
  logic [2:0]                     event_r;

  logic                           awready_r;
  logic                           wready_r;
  logic                           bvalid_r;
  logic [1:0]                     bresp_r;
  logic                           arready_r;
  logic                           rvalid_r;
  logic [1:0]                     rresp_r;
  logic [31:0]                    rdata_r;
  logic [qac_pkg::AXI_ADDR_W-1:0] awaddr_q_r;
  logic [31:0]                    wdata_q_r;
  logic [3:0]                     wstrb_q_r;

  logic                           edge_a;
  logic                           edge_b;
  logic                           rise_a;
  logic                           step;
  logic                           dir_up;
  logic                           rst_hold;
  logic                           do_write;
  logic [31:0]                    count_nxt;

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;
  assign count_value   = count_r;
  assign angle_value   = angle_r;
  assign event_bits    = event_r;

  // ****************************************************************
  // input sampling
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // preload both stages from the pins so no false edge follows reset
      in_s_r <= '{rst: index_reset_input, ph_b: phase_b_input,
                  ph_a: phase_a_input};
      in_p_r <= '{rst: index_reset_input, ph_b: phase_b_input,
                  ph_a: phase_a_input};
    end else begin
      in_s_r <= '{rst: index_reset_input, ph_b: phase_b_input,
                  ph_a: phase_a_input};
      in_p_r <= in_s_r;
    end
  end

  // ****************************************************************
  // edge qualification and direction
  // ****************************************************************
  assign edge_a = in_s_r.ph_a ^ in_p_r.ph_a;
  assign edge_b = in_s_r.ph_b ^ in_p_r.ph_b;
  assign rise_a = in_s_r.ph_a & ~in_p_r.ph_a;
  // forward order of (a,b) is 00, 10, 11, 01
  assign dir_up = in_s_r.ph_a ^ in_p_r.ph_b; // RULE5

  always_comb begin
    case (ctrl_r.prec)
      qac_pkg::QAC_PREC_SINGLE: step = rise_a;            // RULE1
      qac_pkg::QAC_PREC_DOUBLE: step = edge_a;            // RULE2
      qac_pkg::QAC_PREC_QUAD:   step = edge_a ^ edge_b;   // RULE3
      default:                  step = edge_a ^ edge_b;
    endcase
  end

  // level-held clear; polarity follows the invert bit
  assign rst_hold = ctrl_r.ext_rst & (in_s_r.rst ^ ctrl_r.inv); // RULE6

  // ****************************************************************
  // counter
  // ****************************************************************
  always_comb begin
    count_nxt = count_r;
    if (rst_hold) begin
      count_nxt = '0; // RULE7
    end else if (step) begin
      count_nxt = dir_up ? count_r + 32'h0000_0001
                         : count_r - 32'h0000_0001; // RULE4
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt; // RULE8
    end
  end

  // ****************************************************************
  // angle scaling, one cycle behind the count
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      angle_r <= '0;
    end else begin
      angle_r <= 32'(count_r[qac_pkg::POS_W-1:0])
                 * qac_pkg::ANGLE_STEP_UDEG
                 + qac_pkg::ANGLE_OFFSET_UDEG; // RULE11
    end
  end

  // ****************************************************************
  // event bits, each one enabled on its own
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      event_r <= '0;
    end else begin
      event_r <= in_s_r & evt_en_r; // RULE12
    end
  end

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  assign do_write = ~awready_r & ~wready_r & ~bvalid_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r  <= 1'b1;
      wready_r   <= 1'b1;
      bvalid_r   <= 1'b0;
      bresp_r    <= qac_pkg::RESP_OKAY;
      awaddr_q_r <= '0;
      wdata_q_r  <= '0;
      wstrb_q_r  <= '0;
    end else begin
      if (s_axi_awvalid && awready_r) begin
        awaddr_q_r <= s_axi_awaddr;
        awready_r  <= 1'b0;
      end
      if (s_axi_wvalid && wready_r) begin
        wdata_q_r <= s_axi_wdata;
        wstrb_q_r <= s_axi_wstrb;
        wready_r  <= 1'b0;
      end
      if (do_write) begin
        bvalid_r <= 1'b1;
        case (awaddr_q_r)
          qac_pkg::REG_CTRL,
          qac_pkg::REG_EVT_EN,
          qac_pkg::REG_COUNT,
          qac_pkg::REG_ANGLE,
          qac_pkg::REG_INPUTS: bresp_r <= qac_pkg::RESP_OKAY;
          default:             bresp_r <= qac_pkg::RESP_SLVERR;
        endcase
      end
      if (bvalid_r && s_axi_bready) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  // writable registers; count, angle and inputs ignore writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r   <= qac_pkg::qac_ctrl_type'(qac_pkg::CTRL_RST);
      evt_en_r <= qac_pkg::EVT_EN_RST;
    end else if (do_write && wstrb_q_r[0]) begin
      if (awaddr_q_r == qac_pkg::REG_CTRL) begin
        ctrl_r <= qac_pkg::qac_ctrl_type'(
                    wdata_q_r[qac_pkg::CTRL_W-1:0]); // RULE13
      end
      if (awaddr_q_r == qac_pkg::REG_EVT_EN) begin
        evt_en_r <= wdata_q_r[qac_pkg::EVT_W-1:0];
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rresp_r   <= qac_pkg::RESP_OKAY;
      rdata_r   <= '0;
    end else begin
      if (s_axi_arvalid && arready_r) begin
        arready_r <= 1'b0;
        rvalid_r  <= 1'b1;
        rresp_r   <= qac_pkg::RESP_OKAY;
        rdata_r   <= '0;
        case (s_axi_araddr)
          qac_pkg::REG_CTRL:   rdata_r[qac_pkg::CTRL_W-1:0] <= ctrl_r;
          qac_pkg::REG_EVT_EN: rdata_r[qac_pkg::EVT_W-1:0] <= evt_en_r;
          qac_pkg::REG_COUNT:  rdata_r <= count_r;
          qac_pkg::REG_ANGLE:  rdata_r <= angle_r; // RULE10
          qac_pkg::REG_INPUTS: rdata_r[qac_pkg::EVT_W-1:0] <= in_s_r;
          default:             rresp_r <= qac_pkg::RESP_SLVERR;
        endcase
      end
      if (rvalid_r && s_axi_rready) begin
        rvalid_r  <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence seq_step_up;
    step && dir_up && !rst_hold;
  endsequence

  sequence seq_step_down;
    step && !dir_up && !rst_hold;
  endsequence

  sequence seq_hold_two;
    rst_hold [*2];
  endsequence

  sequence seq_quad_b_only;
    ctrl_r.prec == qac_pkg::QAC_PREC_QUAD && edge_b && !edge_a
      && !rst_hold;
  endsequence

  chk_single_a_rise: assert property ( // RULE1
    (ctrl_r.prec == qac_pkg::QAC_PREC_SINGLE && !rise_a && !rst_hold)
      |=> $stable(count_r))
    else $error("single mode counted without a phase A rise");

  chk_double_a_edge: assert property ( // RULE2
    (ctrl_r.prec == qac_pkg::QAC_PREC_DOUBLE && edge_a && !rst_hold)
      |=> count_r != $past(count_r))
    else $error("double mode missed a phase A edge");

  chk_quad_b_edge: assert property ( // RULE3
    seq_quad_b_only |=> count_r != $past(count_r))
    else $error("quad mode missed a phase B edge");

  chk_quad_step_one: assert property ( // RULE4
    (ctrl_r.prec == qac_pkg::QAC_PREC_QUAD) ##0 seq_step_up
      |=> count_r == $past(count_r) + 32'h0000_0001)
    else $error("quad step did not add exactly one");

  chk_dir_down: assert property ( // RULE5
    seq_step_down |=> count_r == $past(count_r) - 32'h0000_0001)
    else $error("reverse step did not subtract one");

  chk_pulse_clear: assert property ( // RULE6
    (ctrl_r.ext_rst && !ctrl_r.inv && in_s_r.rst && !in_p_r.rst)
      |=> count_r == '0)
    else $error("reset pulse did not clear the count");

  chk_high_clears: assert property ( // RULE7
    (ctrl_r.ext_rst && !ctrl_r.inv && in_s_r.rst) |=> count_r == '0)
    else $error("high reset level left a count");

  chk_hold_cleared: assert property ( // RULE8
    seq_hold_two |=> count_r == '0 && $past(count_r) == '0)
    else $error("count moved while reset was held");

  chk_angle_range: assert property ( // RULE10
    angle_r < qac_pkg::ANGLE_FULL_UDEG)
    else $error("angle left the 0 to 360 degree range");

  chk_angle_scale: assert property ( // RULE11
    ##1 angle_r == 32'($past(count_r[qac_pkg::POS_W-1:0]))
                   * qac_pkg::ANGLE_STEP_UDEG)
    else $error("angle is not count times step");

  chk_event_bits: assert property ( // RULE12
    $past(aresetn) |-> event_r == ($past(in_s_r) & $past(evt_en_r)))
    else $error("event bits disagree with sampled inputs");

  chk_invert_low: assert property ( // RULE13
    (ctrl_r.ext_rst && ctrl_r.inv && !in_s_r.rst) |=> count_r == '0)
    else $error("inverted reset low did not clear the count");

  sequence seq_aw_w_taken;
    s_axi_awvalid && awready_r && s_axi_wvalid && wready_r;
  endsequence

  chk_write_answer: assert property (
    seq_aw_w_taken |=> ##1 bvalid_r)
    else $error("write response late after AW and W");

  chk_write_release: assert property (
    (bvalid_r && s_axi_bready) |=> awready_r && wready_r && !bvalid_r)
    else $error("write channel not released after response");

  chk_read_answer: assert property (
    (s_axi_arvalid && arready_r) |=> rvalid_r && !arready_r)
    else $error("read data did not follow the address");

  chk_read_release: assert property (
    (rvalid_r && s_axi_rready) |=> arready_r && !rvalid_r)
    else $error("read channel not released after data");

endmodule : qac_top

// >>> qac_encoder_model.sv
/*
  encoder partner: two quadrature phases and an index reset line.
  assumes step, dir and the reset requests change just after aclk rises.
*/
`timescale 1ns/1ps
module qac_encoder_model (
  input  wire logic aclk,
  input  wire logic step,
  input  wire logic dir,
  input  wire logic rst_lvl,
  input  wire logic rst_pulse,
  output      logic ph_a,
  output      logic ph_b,
  output      logic rst_pin
);
  logic [1:0] idx_r   = 2'h0;
  logic       pulse_r = 1'b0;

  // forward walk of (a,b): 00,10,11,01; one step at a time only
  always_ff @(posedge aclk) begin
    if (step) begin
      idx_r <= dir ? idx_r + 2'h1 : idx_r - 2'h1;
    end
  end

  // index pulse is rst_pulse delayed by one cycle, as long as rst_pulse
  always_ff @(posedge aclk) begin
    pulse_r <= rst_pulse;
  end

  assign ph_a    = idx_r[1] ^ idx_r[0];
  assign ph_b    = idx_r[1];
  assign rst_pin = rst_lvl | pulse_r;
endmodule : qac_encoder_model

// >>> quadrature_angle_counter_tb_top.sv
/*
  self-checking bench for the angle counter over AXI4-Lite.
  assumes qac_top answers each AXI4-Lite request within a few cycles.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  errors++; $display("Error t=%0t got %h exp %h", $time, g, e); end end
module quadrature_angle_counter_tb_top;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic        step = 1'b0, dir = 1'b0, rlvl = 1'b0, rpul = 1'b0;
  logic        ph_a, ph_b, rpin;
  logic [31:0] count_value, angle_value;
  logic [2:0]  event_bits;
  logic [33:0] q[$];
  logic [33:0] ew;
  int          errors = 0, samples_checked = 0, ec = 0, k;

  initial begin
    forever #12.5 aclk = ~aclk;
  end

  qac_top DUT (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .phase_a_input(ph_a), .phase_b_input(ph_b),
    .index_reset_input(rpin), .count_value(count_value),
    .angle_value(angle_value), .event_bits(event_bits));

  qac_encoder_model ENC (.aclk(aclk), .step(step), .dir(dir),
    .rst_lvl(rlvl), .rst_pulse(rpul), .ph_a(ph_a), .ph_b(ph_b),
    .rst_pin(rpin));

  // ****************************************************************
  // result watcher
  // ****************************************************************
  always @(posedge aclk) begin
    if ((bvalid && bready) || (rvalid && rready)) begin
      ew = (q.size() > 0) ? q.pop_front() : 34'h3_FFFF_FFFF;
      if (bvalid && bready) begin
        `CHK({bresp, 32'h0000_0000}, ew)
      end else begin
        `CHK({rresp, rdata}, ew)
      end
    end
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic summarize;
    if (errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    logic pa, pw, pb;
    int   n;
    pa = 1'b1; pw = 1'b1; pb = 1'b1;
    q.push_back({r, 32'h0000_0000});
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 60 && pb; n++) begin
      @(posedge aclk);
      if (pa && awready) begin pa = 1'b0; awvalid <= 1'b0; end
      if (pw && wready) begin pw = 1'b0; wvalid <= 1'b0; end
      if (!pa && !pw && bvalid) begin pb = 1'b0; bready <= 1'b0; end
    end
    // one idle edge so the next call never re-drives bready at once
    @(posedge aclk);
    if (pb) begin errors++; summarize(); end
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    logic pa, pr;
    int   n;
    pa = 1'b1; pr = 1'b1;
    q.push_back(e);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (n = 0; n < 60 && pr; n++) begin
      @(posedge aclk);
      if (pa && arready) begin pa = 1'b0; arvalid <= 1'b0; end
      if (!pa && rvalid) begin pr = 1'b0; rready <= 1'b0; end
    end
    @(posedge aclk);
    if (pr) begin errors++; summarize(); end
  endtask : rd

  task automatic steps(input int n, input logic fwd);
    for (int i = 0; i < n; i++) begin
      step <= 1'b1; dir <= fwd; @(posedge aclk);
      step <= 1'b0; @(posedge aclk);
    end
    repeat (4) @(posedge aclk);
  endtask : steps

  // compares live count and angle and the COUNT and ANGLE registers
  task automatic chk_cnt;
    logic [31:0] ang;
    ang = 32'((ec % 4096 + 4096) % 4096) * qac_pkg::ANGLE_STEP_UDEG;
    `CHK(count_value, 32'(ec))
    `CHK(angle_value, ang)
    rd(qac_pkg::REG_COUNT, {2'h0, 32'(ec)});
    rd(qac_pkg::REG_ANGLE, {2'h0, ang});
  endtask : chk_cnt

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    void'($urandom(89349));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(qac_pkg::REG_CTRL, 34'h0_0000_0004);
    rd(qac_pkg::REG_EVT_EN, 34'h0_0000_0007);
    rd(8'h40, {qac_pkg::RESP_SLVERR, 32'h0000_0000});
    wr(8'h40, 32'h0000_0001, qac_pkg::RESP_SLVERR);
    for (int m = 0; m < 3; m++) begin
      wr(qac_pkg::REG_CTRL, 32'h0000_0004 | 32'(m), 2'h0);
      rpul <= 1'b1; @(posedge aclk); rpul <= 1'b0;
      repeat (4) @(posedge aclk);
      ec = 0;
      `CHK(count_value, 32'h0000_0000)
      k = $urandom_range(4, 1);
      steps(4 * k, 1'b1);
      ec = k << m;
      chk_cnt();
      steps(4, 1'b0);
      ec = ec - (1 << m);
      chk_cnt();
    end
    steps(8, 1'b0);
    ec = ec - 8;
    chk_cnt();
    rlvl <= 1'b1;
    steps(4, 1'b1);
    ec = 0;
    chk_cnt();
    rlvl <= 1'b0;
    wr(qac_pkg::REG_CTRL, 32'h0000_000E, 2'h0);
    steps(4, 1'b1);
    chk_cnt();
    rlvl <= 1'b1;
    steps(5, 1'b1);
    ec = 5;
    chk_cnt();
    // pin ignored with its clear disabled; code 3 acts as quad
    wr(qac_pkg::REG_CTRL, 32'h0000_0003, 2'h0);
    steps(4, 1'b1);
    ec = 9;
    chk_cnt();
    wr(qac_pkg::REG_EVT_EN, 32'h0000_0005, 2'h0);
    repeat (3) @(posedge aclk);
    `CHK(event_bits, {rpin, ph_b, ph_a} & 3'h5)
    rd(qac_pkg::REG_INPUTS, {31'h0, rpin, ph_b, ph_a});
    repeat (2) @(posedge aclk);
    summarize();
  end
endmodule : quadrature_angle_counter_tb_top
